// ===== logic/flash_param_check.sv
// combinational checks of the frequency, destination and source parameters
`timescale 1ns/1ps
`include "flash_prog_regs.svh"
module flash_param_check (
    input  wire logic [31:0] freq_word,
    input  wire logic [31:0] dest_addr,
    input  wire logic [31:0] src_addr,
    output logic             freq_err,
    output logic             dest_range_err,
    output logic             dest_align_err,
    output logic             src_err
);
    wire logic [15:0] freq_field = freq_word[`FP_FREQ_HI:0];
    wire logic        upper_set  = |freq_word[31:`FP_FREQ_HI+1];
    // offsets from the window base, so one unsigned compare covers both ends
    wire logic [31:0] flash_span = `FP_FLASH_END - `FP_FLASH_BASE;
    wire logic [31:0] dest_off   = dest_addr - `FP_FLASH_BASE;
    wire logic [31:0] src_off    = src_addr - `FP_FLASH_BASE;

    assign freq_err = upper_set || (freq_field < `FP_FREQ_MIN) || (freq_field > `FP_FREQ_MAX);
    assign dest_range_err = (dest_off >= flash_span);
    assign dest_align_err = |(dest_addr & `FP_ALIGN_MASK);
    assign src_err = (src_off < flash_span);
endmodule

// ===== logic/flash_prog_pkg.sv
// types for the flash programming parameter check
package flash_prog_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CHECK = 5'h02,
        ST_READ  = 5'h04,
        ST_WRITE = 5'h08,
        ST_DONE  = 5'h10
    } prog_state_e;
endpackage

// ===== logic/flash_prog_regs.svh
// offsets, field positions, limits and counts for the flash programming parameter check
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// user flash array address window, base inclusive, end exclusive
`define FP_FLASH_BASE      32'h0000_0000
`define FP_FLASH_END       32'h0008_0000

// one programming operation covers 128 bytes, given as the last byte index and the alignment mask
`define FP_BURST_LAST      7'h7F
`define FP_ALIGN_MASK      32'h0000_007F

// frequency field, value is MHz times 100
`define FP_FREQ_HI         15
`define FP_FREQ_MIN        16'h0320
`define FP_FREQ_MAX        16'h1388

// program result register bit positions
`define FP_RES_SF          0
`define FP_RES_FQ          1
`define FP_RES_WA          6
`define FP_RES_WD          7
`define FP_RES_RESET       8'h00

`endif

// ===== logic/flash_program_param_check.sv
// parameter intake, validation and 128-byte program sequencer
//
// How it works
// - destination outside flash gives an error
// - destination not 128-byte aligned gives error
// - destination errors set write-address flag
// - program 128 consecutive bytes from destination
// - source inside flash sets write-data flag
// - read 128 source bytes and program them
`timescale 1ns/1ps
`include "flash_prog_regs.svh"
module flash_program_param_check (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        freq_load,
    input  wire logic        prog_start,
    input  wire logic [31:0] cpu_general_register_0,
    input  wire logic [31:0] cpu_general_register_1,
    output logic             mem_rd_en,
    output logic [31:0]      mem_rd_addr,
    input  wire logic [7:0]  mem_rd_data,
    output logic             flash_wr_en,
    output logic [31:0]      flash_wr_addr,
    output logic [7:0]       flash_wr_data,
    output logic             busy,
    output logic             done,
    output logic [7:0]       program_result_register
);
    flash_prog_pkg::prog_state_e state_q;
    flash_prog_pkg::prog_state_e state_d;

    logic [31:0] cpu_frequency_parameter_q;
    logic [31:0] program_destination_address_parameter_q;
    logic [31:0] program_source_address_parameter_q;
    logic [6:0]  idx_q;
    logic        rd_en_q;
    logic [31:0] rd_addr_q;
    logic        wr_en_q;
    logic [31:0] wr_addr_q;
    logic [7:0]  wr_data_q;
    logic        done_q;
    logic [7:0]  result_q;
    logic        busy_q;

    wire logic freq_err;
    wire logic dest_range_err;
    wire logic dest_align_err;
    wire logic src_err;

    ////////////////////////////////////////////////////////////////////////////////
    // parameter checks
    flash_param_check u_check (
        .freq_word      (cpu_frequency_parameter_q),
        .dest_addr      (program_destination_address_parameter_q),
        .src_addr       (program_source_address_parameter_q),
        .freq_err       (freq_err),
        .dest_range_err (dest_range_err),
        .dest_align_err (dest_align_err),
        .src_err        (src_err)
    );

    wire logic dest_err  = dest_range_err || dest_align_err;
    wire logic any_err   = dest_err || src_err || freq_err;
    wire logic in_check  = (state_q == flash_prog_pkg::ST_CHECK);
    wire logic in_write  = (state_q == flash_prog_pkg::ST_WRITE);
    wire logic last_byte = (idx_q == `FP_BURST_LAST);
    wire logic [31:0] offset   = {25'h0000000, idx_q};
    wire logic [31:0] src_next = program_source_address_parameter_q + offset;
    wire logic [31:0] dst_next = program_destination_address_parameter_q + offset;
    wire logic [7:0]  err_bits = {src_err, dest_err, 4'h0, freq_err, 1'b0};

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            flash_prog_pkg::ST_IDLE: begin
                if (prog_start) begin
                    state_d = flash_prog_pkg::ST_CHECK;
                end
            end
            flash_prog_pkg::ST_CHECK: begin
                state_d = any_err ? flash_prog_pkg::ST_DONE : flash_prog_pkg::ST_READ;
            end
            flash_prog_pkg::ST_READ: begin
                state_d = flash_prog_pkg::ST_WRITE;
            end
            flash_prog_pkg::ST_WRITE: begin
                state_d = last_byte ? flash_prog_pkg::ST_DONE : flash_prog_pkg::ST_READ;
            end
            flash_prog_pkg::ST_DONE: begin
                state_d = flash_prog_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= flash_prog_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // parameter intake from the cpu general registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_frequency_parameter_q <= 32'h0000_0000;
        end else if (freq_load && state_q == flash_prog_pkg::ST_IDLE) begin
            cpu_frequency_parameter_q <= cpu_general_register_0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            program_destination_address_parameter_q <= 32'h0000_0000;
            program_source_address_parameter_q      <= 32'h0000_0000;
        end else if (prog_start && state_q == flash_prog_pkg::ST_IDLE) begin
            program_destination_address_parameter_q <= cpu_general_register_1;
            program_source_address_parameter_q      <= cpu_general_register_0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte index, source read, flash write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idx_q <= 7'h00;
        end else if (in_check) begin
            idx_q <= 7'h00;
        end else if (in_write) begin
            idx_q <= idx_q + 7'h01;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_en_q   <= 1'b0;
            rd_addr_q <= 32'h0000_0000;
        end else begin
            rd_en_q <= (state_d == flash_prog_pkg::ST_READ);
            if (state_d == flash_prog_pkg::ST_READ) begin
                rd_addr_q <= in_write ? src_next + 32'h0000_0001 : src_next;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= in_write;
            if (in_write) begin
                wr_addr_q <= dst_next;
                wr_data_q <= mem_rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // program result register and completion
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= `FP_RES_RESET;
        end else if (in_check) begin
            result_q <= err_bits | {7'h00, any_err};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == flash_prog_pkg::ST_DONE);
        end
    end

    // busy registered from the next state, so it rises with start and falls with done
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != flash_prog_pkg::ST_IDLE);
        end
    end

    assign mem_rd_en               = rd_en_q;
    assign mem_rd_addr             = rd_addr_q;
    assign flash_wr_en             = wr_en_q;
    assign flash_wr_addr           = wr_addr_q;
    assign flash_wr_data           = wr_data_q;
    assign busy                    = busy_q;
    assign done                    = done_q;
    assign program_result_register = result_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0] wr_cnt_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_cnt_q <= 8'h00;
        end else if (in_check) begin
            wr_cnt_q <= 8'h00;
        end else if (wr_en_q) begin
            wr_cnt_q <= wr_cnt_q + 8'h01;
        end
    end

    sequence read_then_write_s;
        ##2 (wr_en_q && wr_data_q == $past(mem_rd_data, 1));
    endsequence

    range_err_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (in_check && dest_range_err) |=> result_q[`FP_RES_WA] && result_q[`FP_RES_SF])
        else $error("out of range destination not flagged");

    align_err_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (in_check && !dest_range_err && dest_align_err) |=> result_q[`FP_RES_WA])
        else $error("misaligned destination not flagged");

    wa_flag_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
        in_check |=> result_q[`FP_RES_WA] == $past(dest_err, 1))
        else $error("write address flag does not match destination check");

    src_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
        in_check |=> ##1 (done_q && result_q[`FP_RES_WD] == $past(src_err, 2)) or
        (!$past(src_err, 1) && !result_q[`FP_RES_WD]))
        else $error("write data flag does not match source check");

    burst_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (done_q && !result_q[`FP_RES_SF]) |-> wr_cnt_q == 8'h80)
        else $error("burst did not write 128 bytes");

    read_to_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        rd_en_q |-> read_then_write_s ##0
        (wr_addr_q - program_destination_address_parameter_q ==
         $past(rd_addr_q, 2) - program_source_address_parameter_q))
        else $error("source byte not written at matching offset");

    no_write_err_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (in_check && any_err) |=> (!wr_en_q && !rd_en_q)[*2] ##0 done_q)
        else $error("flash touched after parameter error");
endmodule

// ===== sim/flash_src_mem.sv
// source data memory model answering the sequencer's byte reads
`timescale 1ns/1ps
module flash_src_mem (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        mem_rd_en,
    input  wire logic [31:0] mem_rd_addr,
    output logic [7:0]       mem_rd_data
);
    // data valid the cycle after a read, a changing pattern otherwise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_rd_data <= 8'h00;
        end else if (mem_rd_en) begin
            mem_rd_data <= mem_rd_addr[7:0] ^ mem_rd_addr[15:8] ^ 8'h5A;
        end else begin
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule

// ===== sim/tb_top.sv
// testbench for the flash programming parameter check
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        freq_load = 1'b0;
    logic        prog_start = 1'b0;
    logic [31:0] reg0 = 32'h0;
    logic [31:0] reg1 = 32'h0;
    logic        rd_en, wr_en, busy, done;
    logic [31:0] rd_addr, wr_addr;
    logic [7:0]  rd_data, wr_data, result;
    int          errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    integer      seed = 32987;
    logic [39:0] exp_wr[$];
    logic [7:0]  exp_res[$];
    logic [39:0] e;
    logic [7:0]  exp_r;
    logic [31:0] tf[9] = '{32'h0DAC, 32'h0320, 32'h1388, 32'h0DAC, 32'h0DAC,
                           32'h0DAC, 32'h0DAC, 32'h031F, 32'h0DAC};
    logic [31:0] ts[9] = '{32'h00FFA000, 32'h00FFA001, 32'h00080000, 32'h00FFA000,
                           32'h00FFA000, 32'h0007FFFF, 32'h0, 32'h00FFA000, 32'h0};
    logic [31:0] td[9] = '{32'h1000, 32'h0007FF80, 32'h0, 32'h1040, 32'h00080000,
                           32'h1000, 32'h00080001, 32'h1000, 32'h0};
    logic [7:0]  tr[9] = '{8'h00, 8'h00, 8'h00, 8'h41, 8'h41, 8'h81, 8'hC1, 8'h03, 8'h00};

    initial begin
        forever #50 mclk = ~mclk;
    end

    flash_program_param_check i_dut (
        .mclk                    (mclk),
        .arst_n                  (arst_n),
        .freq_load               (freq_load),
        .prog_start              (prog_start),
        .cpu_general_register_0  (reg0),
        .cpu_general_register_1  (reg1),
        .mem_rd_en               (rd_en),
        .mem_rd_addr             (rd_addr),
        .mem_rd_data             (rd_data),
        .flash_wr_en             (wr_en),
        .flash_wr_addr           (wr_addr),
        .flash_wr_data           (wr_data),
        .busy                    (busy),
        .done                    (done),
        .program_result_register (result)
    );

    flash_src_mem i_mem (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .mem_rd_en   (rd_en),
        .mem_rd_addr (rd_addr),
        .mem_rd_data (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic run(input logic [31:0] fq, src, dst, input logic [7:0] res);
        int i;
        logic [31:0] a;
        @(negedge mclk);
        freq_load = 1'b1;
        reg0 = fq;
        @(negedge mclk);
        freq_load = 1'b0;
        prog_start = 1'b1;
        reg0 = src;
        reg1 = dst;
        exp_res.push_back(res);
        for (i = 0; i < 128 && res === 8'h00; i++) begin
            a = src + i;
            exp_wr.push_back({dst + i, a[7:0] ^ a[15:8] ^ 8'h5A});
        end
        @(negedge mclk);
        prog_start = 1'b0;
        `CHK(busy, 1'b1)
        if (res === 8'h00) begin
            repeat (5) @(negedge mclk);
            prog_start = 1'b1;
            reg0 = 32'h1;
            reg1 = 32'h3;
            @(negedge mclk);
            prog_start = 1'b0;
        end
        for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge mclk);
        @(negedge mclk);
        $display("test done src %h dst %h", src, dst);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge mclk) begin
        if (wr_en === 1'b1) begin
            e = (exp_wr.size() > 0) ? exp_wr.pop_front() : 40'h0;
            `CHK({wr_addr, wr_data}, e)
        end
        if (done === 1'b1) begin
            exp_r = (exp_res.size() > 0) ? exp_res.pop_front() : 8'hFF;
            `CHK(result, exp_r)
            `CHK(busy, 1'b0)
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 8000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        for (int k = 0; k < 9; k++) begin
            if (k == 8) begin
                ts[k] = 32'h00FF0000 | ($random(seed) & 32'hFFFF);
                td[k] = $random(seed) & 32'h0007FF80;
            end
            run(tf[k], ts[k], td[k], tr[k]);
        end
        `CHK(exp_wr.size() + exp_res.size(), 0)
        end_of_test();
    end
endmodule
